/* logic/sdc_consts.vh */
// named constants of the cpu port serdes block
// assumes inclusion by bare name from the design files
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH
// link framing
`define SDC_START_BIT 1'b1
`define SDC_RW_READ 1'b1
`define SDC_HDR_EDGES 4'h2
`define SDC_WR_EDGES 4'hA
`define SDC_FRAME_MC 4'h5
// slave write timing, in link clock cycles
`define SDC_SLV_WR_LAT_MC 4'h9
`define SDC_WR_SETUP_MC 4'h1
`define SDC_WR_STB_MC 4'h3
`define SDC_WR_HOLD_MC 4'h1
// slave read timing, in link clock cycles
`define SDC_SLV_RD_LAT_MC 4'h6
`define SDC_RD_DLY_MC 4'h1
`define SDC_RD_STB_MC 4'h6
`define SDC_RD_RET_MC 4'h4
`define SDC_RD_BITS 4'h9
// master read-ready timing, in link clock cycles
`define SDC_IRQ_DLY_MC 4'hC
`define SDC_IRQ_CLR_MC 4'h5
// buffer entry layout
`define SDC_ENT_W 19
`define SDC_ENT_RW 18
`define SDC_ENT_AD 17
`define SDC_ENT_CS 16
`endif

/* logic/sdc_word_fifo.v */
// small word buffer with registered read data
// assumes one clock; srst empties it synchronously
`timescale 1ns/100ps
`default_nettype none
module sdc_word_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_q;
  reg [AW-1:0] rptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;
  assign in_ready = (count_q != DEPTH[AW:0]);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // pointers, fill count and registered head word
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (srst) begin
        wptr_q <= {AW{1'b0}};
        rptr_q <= {AW{1'b0}};
        count_q <= {(AW+1){1'b0}};
        out_valid <= 1'b0;
      end else begin
        if (push) wptr_q <= wptr_q + 1'b1;
        if (pop) rptr_q <= rptr_q + 1'b1;
        count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        out_valid <= (count_q != {(AW+1){1'b0}}) & ~pop; // bubble after pop
        out_data <= mem[rptr_q];
      end
    end
  end
  // storage
  always @(posedge sys_clk) begin
    if (clk_en & push & ~srst) mem[wptr_q] <= in_data;
  end
endmodule // sdc_word_fifo
`default_nettype wire

/* logic/sdc_cpu_port.v */
// cpu-style parallel port of a serdes device, master or slave role
// assumes all pins asynchronous to sys_clk; link clock is sampled
`timescale 1ns/100ps
`default_nettype none
`include "sdc_consts.vh"
module sdc_cpu_port #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  input wire link_power_down_n,
  input wire role_master_strap,
  input wire split_strobe_style_mode,
  input wire serial_link_clock,
  input wire serial_lane_low_in,
  output reg serial_lane_low_out,
  output reg serial_lane_low_oe,
  input wire serial_lane_high_in,
  output reg serial_lane_high_out,
  output reg serial_lane_high_oe,
  input wire host_cs1_n,
  input wire host_cs2_n,
  input wire host_e_wr_n,
  input wire host_rw_rd_n,
  input wire host_ad,
  input wire [15:0] host_data_in,
  output reg [15:0] host_data_out,
  output reg host_data_oe,
  output reg read_ready_irq,
  output reg host_fifo_full,
  output reg pll_enable,
  output reg link_drive_en,
  output reg main_display_select_n,
  output reg sub_display_select_n,
  output reg disp_e_wr_n,
  output reg disp_rw_rd_n,
  output reg disp_ad,
  input wire [15:0] disp_data_in,
  output reg [15:0] disp_data_out,
  output reg disp_data_oe,
  output reg disp_clk_out,
  output reg mode_function_out0,
  output reg mode_function_out1
);
  // ----------------------------------------------------------------
  // input synchronisers and link clock edges
  // ----------------------------------------------------------------
  localparam SW = 43;
  reg [SW-1:0] s1_q;
  reg [SW-1:0] s2_q;
  reg mc_prev_q;
  wire [SW-1:0] pins = {link_power_down_n, role_master_strap, split_strobe_style_mode,
    serial_link_clock, serial_lane_high_in, serial_lane_low_in, host_cs1_n, host_cs2_n,
    host_e_wr_n, host_rw_rd_n, host_ad, host_data_in, disp_data_in};
  wire pd_n_s = s2_q[42];
  wire role_s = s2_q[41];
  wire split_s = s2_q[40];
  wire mc_s = s2_q[39];
  wire lhi_s = s2_q[38];
  wire llo_s = s2_q[37];
  wire cs1_s = s2_q[36];
  wire cs2_s = s2_q[35];
  wire ewr_s = s2_q[34];
  wire rwrd_s = s2_q[33];
  wire ad_s = s2_q[32];
  wire [15:0] hdata_s = s2_q[31:16];
  wire [15:0] ddata_s = s2_q[15:0];
  wire pd = ~pd_n_s;
  wire mc_rise = mc_s & ~mc_prev_q;
  wire mc_edge = mc_s ^ mc_prev_q;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_q <= {SW{1'b0}};
      s2_q <= {SW{1'b0}};
      mc_prev_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= pins;
      s2_q <= s1_q;
      mc_prev_q <= mc_s;
    end
  end
  // straps caught in power-down only
  reg role_q;
  reg split_q;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      role_q <= 1'b0;
      split_q <= 1'b0;
    end else if (clk_en & pd) begin
      role_q <= role_s;
      split_q <= split_s;
    end
  end
  // ----------------------------------------------------------------
  // master host port and write buffer
  // ----------------------------------------------------------------
  wire cs_any = ~cs1_s | ~cs2_s;
  wire wr_acc = cs_any & (split_q ? ~ewr_s : (ewr_s & ~rwrd_s));
  wire rd_acc = cs_any & (split_q ? ~rwrd_s : (ewr_s & rwrd_s));
  reg wr_acc_q;
  reg rd_acc_q;
  reg rd_busy_q;
  reg [`SDC_ENT_W-1:0] ent_prev_q;
  wire wr_take = role_q & wr_acc_q & ~wr_acc; // first of cs rise or e fall (wr rise in split mode)
  wire rd_start = role_q & rd_acc & ~rd_acc_q;
  wire rd_first = rd_start & ~rd_busy_q;
  wire rd_second = rd_start & read_ready_irq;
  wire f_in_ready;
  wire f_out_valid;
  wire [`SDC_ENT_W-1:0] f_out_data;
  wire f_pop;
  wire [`SDC_ENT_W-1:0] f_in_data = wr_take ? ent_prev_q :
    {`SDC_RW_READ, ad_s, ~cs1_s, 16'h0000};
  sdc_word_fifo #(.WIDTH(`SDC_ENT_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .srst(pd),
    .in_valid(wr_take | rd_first),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );
  // ----------------------------------------------------------------
  // master serialiser and read return
  // ----------------------------------------------------------------
  localparam M_IDLE = 5'h01;
  localparam M_SEND = 5'h02;
  localparam M_TURN = 5'h04;
  localparam M_RECV = 5'h08;
  localparam M_IRQW = 5'h10;
  reg [4:0] m_st_q;
  reg [3:0] m_cnt_q;
  reg [3:0] clr_cnt_q;
  reg clr_run_q;
  reg m_rw_q;
  reg [9:0] m_lo_q;
  reg [9:0] m_hi_q;
  reg [15:0] m_rx_q;
  reg m_lo_out_q;
  reg m_hi_out_q;
  reg m_oe_q;
  reg irq_q;
  // a read pair blocks further traffic
  assign f_pop = role_q & (m_st_q == M_IDLE) & mc_rise & ~rd_busy_q;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      m_st_q <= M_IDLE;
      m_cnt_q <= 4'h0;
      clr_cnt_q <= 4'h0;
      clr_run_q <= 1'b0;
      m_rw_q <= 1'b0;
      m_lo_q <= 10'h000;
      m_hi_q <= 10'h000;
      m_rx_q <= 16'h0000;
      m_lo_out_q <= 1'b0;
      m_hi_out_q <= 1'b0;
      m_oe_q <= 1'b0;
      irq_q <= 1'b0;
      rd_busy_q <= 1'b0;
      wr_acc_q <= 1'b0;
      rd_acc_q <= 1'b0;
      ent_prev_q <= {`SDC_ENT_W{1'b0}};
    end else if (clk_en) begin
      if (pd) begin // power-down returns to M_IDLE and clears oe, irq, busy and access flags
        m_st_q <= M_IDLE;
        m_oe_q <= 1'b0;
        irq_q <= 1'b0;
        rd_busy_q <= 1'b0;
        clr_run_q <= 1'b0;
        wr_acc_q <= 1'b0;
        rd_acc_q <= 1'b0;
      end else begin
        wr_acc_q <= wr_acc;
        rd_acc_q <= rd_acc;
        ent_prev_q <= {1'b0, ad_s, ~cs1_s, hdata_s};
        if (rd_first & f_in_ready) rd_busy_q <= 1'b1;
        // second read clears the flag five link cycles later
        if (rd_second & ~clr_run_q) begin
          clr_run_q <= 1'b1;
          clr_cnt_q <= `SDC_IRQ_CLR_MC - 4'h1;
        end else if (clr_run_q & mc_rise) begin
          if (clr_cnt_q == 4'h0) begin
            clr_run_q <= 1'b0;
            irq_q <= 1'b0;
            rd_busy_q <= 1'b0;
          end else clr_cnt_q <= clr_cnt_q - 4'h1;
        end
        case (m_st_q)
          M_IDLE: if (f_pop & f_out_valid) begin
            m_rw_q <= f_out_data[`SDC_ENT_RW];
            m_lo_q <= {1'b0, f_out_data[7:0], f_out_data[`SDC_ENT_AD]};
            m_hi_q <= {1'b0, f_out_data[15:8], f_out_data[`SDC_ENT_CS]};
            m_lo_out_q <= `SDC_START_BIT;
            m_hi_out_q <= f_out_data[`SDC_ENT_RW];
            m_oe_q <= 1'b1;
            m_cnt_q <= f_out_data[`SDC_ENT_RW] ? `SDC_HDR_EDGES - 4'h1 :
              `SDC_WR_EDGES - 4'h1; // frame of five link cycles
            m_st_q <= M_SEND;
          end
          M_SEND: if (mc_edge) begin
            if (m_cnt_q == 4'h0) begin
              m_lo_out_q <= 1'b0;
              m_hi_out_q <= 1'b0;
              m_oe_q <= ~m_rw_q; // turn lanes round for a read
              m_st_q <= m_rw_q ? M_TURN : M_IDLE;
            end else begin
              m_lo_out_q <= m_lo_q[0];
              m_hi_out_q <= m_hi_q[0];
              m_lo_q <= m_lo_q >> 1;
              m_hi_q <= m_hi_q >> 1;
              m_cnt_q <= m_cnt_q - 4'h1;
            end
          end
          M_TURN: if (mc_rise & llo_s) begin
            m_cnt_q <= `SDC_RD_BITS - 4'h2;
            m_st_q <= M_RECV;
          end
          M_RECV: if (mc_rise) begin
            m_rx_q <= {lhi_s, m_rx_q[15:9], llo_s, m_rx_q[7:1]};
            if (m_cnt_q == 4'h0) begin
              m_cnt_q <= `SDC_IRQ_DLY_MC - 4'h1;
              m_st_q <= M_IRQW;
            end else m_cnt_q <= m_cnt_q - 4'h1;
          end
          M_IRQW: if (mc_rise) begin
            if (m_cnt_q == 4'h0) begin
              irq_q <= 1'b1; // twelve cycles after return data
              m_oe_q <= 1'b1; // master takes lanes back, low
              m_st_q <= M_IDLE;
            end else m_cnt_q <= m_cnt_q - 4'h1;
          end
          default: m_st_q <= M_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // slave deserialiser and display strobes
  // ----------------------------------------------------------------
  localparam S_IDLE = 11'h001;
  localparam S_RX = 11'h002;
  localparam S_WLAT = 11'h004;
  localparam S_WSET = 11'h008;
  localparam S_WSTB = 11'h010;
  localparam S_WHLD = 11'h020;
  localparam S_RLAT = 11'h040;
  localparam S_RSTB = 11'h080;
  localparam S_RRET = 11'h100;
  localparam S_RSEND = 11'h200;
  localparam S_RTA = 11'h400;
  reg [10:0] s_st_q;
  reg [3:0] s_cnt_q;
  reg [9:0] s_lo_q;
  reg [9:0] s_hi_q;
  reg s_ad_q;
  reg s_cs_q;
  reg [15:0] s_data_q;
  reg [8:0] s_txl_q;
  reg [8:0] s_txh_q;
  reg s_lo_out_q;
  reg s_hi_out_q;
  reg s_oe_q;
  wire [9:0] s_lo_n = {llo_s, s_lo_q[9:1]};
  wire [9:0] s_hi_n = {lhi_s, s_hi_q[9:1]};
  wire s_tick = mc_rise & (s_cnt_q == 4'h0);
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_st_q <= S_IDLE;
      s_cnt_q <= 4'h0;
      s_lo_q <= 10'h000;
      s_hi_q <= 10'h000;
      s_ad_q <= 1'b1;
      s_cs_q <= 1'b1;
      s_data_q <= 16'h0000;
      s_txl_q <= 9'h000;
      s_txh_q <= 9'h000;
      s_lo_out_q <= 1'b0;
      s_hi_out_q <= 1'b0;
      s_oe_q <= 1'b0;
    end else if (clk_en) begin
      if (pd | role_q) begin
        s_st_q <= S_IDLE;
        s_oe_q <= 1'b0;
        s_ad_q <= 1'b1;
      end else begin
        if (mc_rise & (s_cnt_q != 4'h0)) s_cnt_q <= s_cnt_q - 4'h1;
        case (s_st_q)
          S_IDLE: if (mc_edge & llo_s) begin
            s_lo_q <= s_lo_n;
            s_hi_q <= s_hi_n;
            s_cnt_q <= 4'h1;
            s_st_q <= S_RX;
          end
          S_RX: if (mc_edge) begin
            s_lo_q <= s_lo_n;
            s_hi_q <= s_hi_n;
            s_cnt_q <= s_cnt_q + 4'h1;
            if ((s_cnt_q == `SDC_HDR_EDGES - 4'h1) & (s_hi_q[9] == `SDC_RW_READ)) begin
              s_ad_q <= llo_s;
              s_cs_q <= lhi_s;
              s_oe_q <= 1'b1; // lanes driven low during turnaround
              s_cnt_q <= `SDC_SLV_RD_LAT_MC + `SDC_RD_DLY_MC - 4'h1;
              s_st_q <= S_RLAT;
            end else if (s_cnt_q == `SDC_WR_EDGES - 4'h1) begin
              s_ad_q <= s_lo_n[1];
              s_cs_q <= s_hi_n[1];
              s_data_q <= {s_hi_n[9:2], s_lo_n[9:2]};
              s_cnt_q <= `SDC_SLV_WR_LAT_MC - `SDC_FRAME_MC - `SDC_WR_SETUP_MC;
              s_st_q <= S_WLAT;
            end
          end
          S_WLAT: if (s_tick) begin
            s_cnt_q <= `SDC_WR_SETUP_MC - 4'h1;
            s_st_q <= S_WSET;
          end
          S_WSET: if (s_tick) begin
            s_cnt_q <= `SDC_WR_STB_MC - 4'h1;
            s_st_q <= S_WSTB;
          end
          S_WSTB: if (s_tick) begin
            s_cnt_q <= `SDC_WR_HOLD_MC - 4'h1;
            s_st_q <= S_WHLD;
          end
          S_WHLD: if (s_tick) s_st_q <= S_IDLE;
          S_RLAT: if (s_tick) begin
            s_cnt_q <= `SDC_RD_STB_MC - 4'h1;
            s_st_q <= S_RSTB;
          end
          S_RSTB: if (s_tick) begin
            s_txl_q <= {ddata_s[7:0], `SDC_START_BIT}; // latched at strobe rise
            s_txh_q <= {ddata_s[15:8], `SDC_START_BIT};
            s_cnt_q <= `SDC_RD_RET_MC - 4'h1;
            s_st_q <= S_RRET;
          end
          S_RRET: if (s_tick) begin
            s_cnt_q <= `SDC_RD_BITS - 4'h1;
            s_st_q <= S_RSEND;
          end
          S_RSEND: if (mc_rise) begin
            s_lo_out_q <= s_txl_q[0];
            s_hi_out_q <= s_txh_q[0];
            s_txl_q <= s_txl_q >> 1;
            s_txh_q <= s_txh_q >> 1;
            if (s_cnt_q == 4'h0) s_st_q <= S_RTA;
          end
          S_RTA: if (mc_rise) begin
            if (s_lo_out_q | s_hi_out_q) begin
              s_lo_out_q <= 1'b0;
              s_hi_out_q <= 1'b0;
            end else begin
              s_oe_q <= 1'b0;
              s_st_q <= S_IDLE;
            end
          end
          default: s_st_q <= S_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  wire act_w = (s_st_q == S_WSET) | (s_st_q == S_WSTB) | (s_st_q == S_WHLD);
  wire stb_w = (s_st_q == S_WSTB);
  wire stb_r = (s_st_q == S_RSTB);
  wire cs_low = split_q ? (act_w | stb_r) : (stb_w | stb_r);
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      serial_lane_low_out <= 1'b0;
      serial_lane_low_oe <= 1'b0;
      serial_lane_high_out <= 1'b0;
      serial_lane_high_oe <= 1'b0;
      host_data_out <= 16'h0000;
      host_data_oe <= 1'b0;
      read_ready_irq <= 1'b0;
      host_fifo_full <= 1'b0;
      pll_enable <= 1'b0;
      link_drive_en <= 1'b0;
      main_display_select_n <= 1'b1;
      sub_display_select_n <= 1'b1;
      disp_e_wr_n <= 1'b1;
      disp_rw_rd_n <= 1'b1;
      disp_ad <= 1'b1;
      disp_data_out <= 16'h0000;
      disp_data_oe <= 1'b0;
      disp_clk_out <= 1'b0;
      mode_function_out0 <= 1'b1;
      mode_function_out1 <= 1'b1;
    end else if (clk_en) begin
      serial_lane_low_out <= ~pd & (role_q ? m_lo_out_q : s_lo_out_q);
      serial_lane_high_out <= ~pd & (role_q ? m_hi_out_q : s_hi_out_q);
      serial_lane_low_oe <= ~pd & (role_q ? m_oe_q : s_oe_q);
      serial_lane_high_oe <= ~pd & (role_q ? m_oe_q : s_oe_q);
      link_drive_en <= ~pd;
      pll_enable <= ~pd & role_q;
      read_ready_irq <= irq_q;
      host_fifo_full <= role_q & ~f_in_ready;
      host_data_oe <= ~pd & role_q & rd_acc;
      if (rd_second) host_data_out <= m_rx_q;
      else if (rd_start) host_data_out <= 16'h0000; // first read is zeros
      if (pd) begin
        main_display_select_n <= 1'b1;
        sub_display_select_n <= ~split_q;
        disp_e_wr_n <= 1'b1;
        disp_rw_rd_n <= 1'b1;
        disp_ad <= 1'b1;
        disp_data_out <= 16'h0000;
        disp_data_oe <= 1'b0;
        disp_clk_out <= 1'b0;
      end else begin
        main_display_select_n <= ~(cs_low & s_cs_q);
        sub_display_select_n <= ~(cs_low & ~s_cs_q);
        disp_e_wr_n <= split_q ? ~stb_w : 1'b1;
        disp_rw_rd_n <= split_q ? ~stb_r : ~act_w;
        disp_ad <= s_ad_q;
        disp_data_out <= act_w ? s_data_q : 16'h0000;
        disp_data_oe <= act_w;
        if (mc_rise & ~role_q) disp_clk_out <= ~disp_clk_out;
      end
      mode_function_out0 <= 1'b1;
      mode_function_out1 <= 1'b1;
    end
  end
endmodule // sdc_cpu_port
`default_nettype wire

/* testbench/sdc_cpu_port_properties.sv */
// checker of the cpu port serdes block, bound to its top module
// assumes every watched port lives in the sys_clk domain, reset high
`timescale 1ns/100ps
`default_nettype none
module sdc_cpu_port_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic link_power_down_n,
  input wire logic role_master_strap,
  input wire logic split_strobe_style_mode,
  input wire logic serial_lane_low_oe,
  input wire logic serial_lane_high_oe,
  input wire logic read_ready_irq,
  input wire logic pll_enable,
  input wire logic link_drive_en,
  input wire logic main_display_select_n,
  input wire logic sub_display_select_n,
  input wire logic disp_e_wr_n,
  input wire logic disp_rw_rd_n,
  input wire logic disp_ad,
  input wire logic [15:0] disp_data_out,
  input wire logic disp_data_oe,
  input wire logic disp_clk_out,
  input wire logic mode_function_out0,
  input wire logic mode_function_out1
);
  // ------------------------------
  // strobe low-time counters
  // ------------------------------
  logic [8:0] cs_lo_q, wr_lo_q, rd_lo_q;
  wire slv_rw = !split_strobe_style_mode && !role_master_strap;
  wire slv_sp = split_strobe_style_mode && !role_master_strap;
  // sys_clk cycles each strobe has stayed low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cs_lo_q <= 9'h000;
      wr_lo_q <= 9'h000;
      rd_lo_q <= 9'h000;
    end else begin
      cs_lo_q <= main_display_select_n ? 9'h000 : cs_lo_q + 9'h001;
      wr_lo_q <= disp_e_wr_n ? 9'h000 : wr_lo_q + 9'h001;
      rd_lo_q <= disp_rw_rd_n ? 9'h000 : rd_lo_q + 9'h001;
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_enable_held_high: assert property (link_power_down_n && slv_rw |-> disp_e_wr_n)
    else $error("enable output left its high level");
  a_select_width: assert property ($rose(main_display_select_n) && slv_rw |->
    cs_lo_q inside {[9'h05B:9'h060], [9'h0B8:9'h0BF]})
    else $error("select low width wrong");
  a_wr_width: assert property ($rose(disp_e_wr_n) && slv_sp |->
    wr_lo_q inside {[9'h05B:9'h060]})
    else $error("write strobe low width wrong");
  a_rd_width: assert property ($rose(disp_rw_rd_n) && slv_sp |->
    rd_lo_q inside {[9'h0B8:9'h0BF]})
    else $error("read strobe low width wrong");
  a_wr_setup: assert property ($fell(disp_e_wr_n) && slv_sp |->
    disp_data_oe && disp_data_out == $past(disp_data_out, 20))
    else $error("write data not set up before strobe");
  a_cs_setup: assert property ($fell(main_display_select_n) && slv_rw && disp_data_oe |->
    disp_data_out == $past(disp_data_out, 20))
    else $error("write data not set up before select");
  a_wr_data_hold: assert property (($rose(disp_e_wr_n) || $rose(main_display_select_n) ||
    $rose(sub_display_select_n)) && disp_data_oe |-> $stable(disp_data_out) [*8])
    else $error("write data not held after strobe");
  a_pd_link_off: assert property (!link_power_down_n [*5] |-> !link_drive_en &&
    !serial_lane_low_oe && !serial_lane_high_oe && !pll_enable)
    else $error("link still driven in power-down");
  a_pd_irq_low: assert property (!link_power_down_n [*5] |-> !read_ready_irq)
    else $error("irq high in power-down");
  a_pd_disp_pins: assert property (!link_power_down_n [*5] |-> disp_ad &&
    main_display_select_n && !disp_clk_out && disp_data_out == 16'h0000 &&
    mode_function_out0 && mode_function_out1)
    else $error("display pins wrong in power-down");
  a_pd_sub_sel: assert property ((!link_power_down_n && $stable(split_strobe_style_mode)) [*6]
    |-> sub_display_select_n == !split_strobe_style_mode)
    else $error("sub select wrong in power-down");
  a_pll_role: assert property (link_power_down_n [*8] |-> pll_enable == role_master_strap)
    else $error("pll enable does not follow role");
endmodule // sdc_cpu_port_chk

bind sdc_cpu_port sdc_cpu_port_chk u_chk (.*);
`default_nettype wire

/* testbench/sdc_link_far_end.sv */
// far end of the serial link: link clock, frames out, read data back
// assumes the bench resolves the lanes and feeds them back here
`timescale 1ns/100ps
`default_nettype none
module sdc_link_far_end (
  input wire logic lane_lo,
  input wire logic lane_hi,
  output logic serial_link_clock,
  output logic far_lo,
  output logic far_hi,
  output logic far_oe
);
  realtime t_q[$];
  logic [15:0] rd_word;
  // ------------------------------
  // link clock, free running, phase unrelated to sys_clk
  // ------------------------------
  initial begin
    serial_link_clock = 1'b0;
    far_lo = 1'b0;
    far_hi = 1'b0;
    far_oe = 1'b1;
    #17.3;
    forever #62.5 serial_link_clock = ~serial_link_clock;
  end
  // one bit per link edge, lsb first, set a quarter cycle each side of it
  task automatic send(input logic ad, input logic rw, input logic cs,
                      input logic [15:0] d, input int n);
    logic [9:0] l, h;
    l = {d[7:0], ad, 1'b1};
    h = {d[15:8], cs, rw};
    repeat (10) @(negedge serial_link_clock); // slave busy 13 link cycles a write
    #31.25;
    for (int i = 0; i < n; i++) begin
      far_lo <= l[i];
      far_hi <= h[i];
      @(serial_link_clock);
      if (i == 0) t_q.push_back($realtime);
      #31.25;
    end
    far_lo <= 1'b0;
    far_hi <= 1'b0;
  endtask
  // read command, turn the lanes round, take start plus 8 bits on rises
  task automatic read_word(input logic ad, input logic cs);
    send(ad, 1'b1, cs, 16'h0000, 2);
    far_oe <= 1'b0;
    repeat (7) @(posedge serial_link_clock);
    for (int k = 0; k < 40 && !lane_lo; k++) @(posedge serial_link_clock);
    for (int i = 0; i < 8; i++) begin
      @(posedge serial_link_clock);
      rd_word[i] = lane_lo;
      rd_word[8 + i] = lane_hi;
    end
    repeat (2) @(posedge serial_link_clock);
    far_oe <= 1'b1;
  endtask
endmodule // sdc_link_far_end
`default_nettype wire

/* testbench/serdes_cpu_port_timing_tb.sv */
// self-checking bench of the cpu port serdes block, slave and master role
// assumes the far-end model makes the link clock and the frames
`timescale 1ns/100ps
`default_nettype none
module serdes_cpu_port_timing_tb;
  // ------------------------------
  // stimulus, wires and model state
  // ------------------------------
  logic sys_clk = 1'b0, reset = 1'b1, link_power_down_n = 1'b0;
  logic role_m = 1'b0, split_m = 1'b0, tgl = 1'b0, rd_mode = 1'b0;
  logic host_cs1_n = 1'b1, host_cs2_n = 1'b1, host_e_wr_n = 1'b0;
  logic host_rw_rd_n = 1'b1, host_ad = 1'b0, stb, stb_q = 1'b1, cs_f = 1'b0;
  logic [15:0] host_data_in = 16'h0000, disp_data_in = 16'h0000;
  logic [9:0] gl, gh;
  logic [31:0] w;
  logic [17:0] exp_q[$];
  wire lo_out, lo_oe, hi_out, hi_oe, main_n, sub_n, dwr, drd, dad;
  wire far_lo, far_hi, far_oe, serial_link_clock;
  wire [15:0] dout;
  integer seed = 32'hB5D60B21;
  int failures = 0, num_checks = 0, cyc = 0;
  realtime dt, lat;
  // undriven lanes toggle every cycle
  wire lane_lo = lo_oe ? lo_out : (far_oe && !role_m) ? far_lo : tgl;
  wire lane_hi = hi_oe ? hi_out : (far_oe && !role_m) ? far_hi : ~tgl;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) tgl <= ~tgl;
  sdc_link_far_end u_far (.lane_lo, .lane_hi, .serial_link_clock, .far_lo, .far_hi, .far_oe);
  sdc_cpu_port u_dut (.sys_clk, .reset, .clk_en(1'b1),
    .link_power_down_n, .role_master_strap(role_m),
    .split_strobe_style_mode(split_m), .serial_link_clock,
    .serial_lane_low_in(lane_lo), .serial_lane_low_out(lo_out), .serial_lane_low_oe(lo_oe),
    .serial_lane_high_in(lane_hi), .serial_lane_high_out(hi_out), .serial_lane_high_oe(hi_oe),
    .host_cs1_n, .host_cs2_n, .host_e_wr_n, .host_rw_rd_n, .host_ad, .host_data_in,
    .host_data_out(), .host_data_oe(), .read_ready_irq(), .host_fifo_full(), .pll_enable(),
    .link_drive_en(), .main_display_select_n(main_n), .sub_display_select_n(sub_n),
    .disp_e_wr_n(dwr), .disp_rw_rd_n(drd), .disp_ad(dad), .disp_data_in,
    .disp_data_out(dout), .disp_data_oe(), .disp_clk_out(), .mode_function_out0(),
    .mode_function_out1());
  // ------------------------------
  // checking helpers
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // power down, set straps, check idle pins, release
  task automatic pd_cfg(input logic r, input logic s);
    @(posedge sys_clk);
    link_power_down_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    role_m <= r;
    split_m <= s;
    host_e_wr_n <= s;
    repeat (12) @(posedge sys_clk);
    chk(sub_n, !s);
    chk(main_n, 1'b1);
    link_power_down_n <= 1'b1;
    repeat (4) @(posedge serial_link_clock);
    @(posedge sys_clk);
  endtask
  // host write, strobe ends before select rises
  task automatic host_wr(input logic cs, input logic ad, input logic [15:0] d);
    @(posedge sys_clk);
    host_cs1_n <= !cs;
    host_cs2_n <= cs;
    host_ad <= ad;
    host_data_in <= d;
    host_rw_rd_n <= split_m;
    host_e_wr_n <= !split_m;
    repeat (8) @(posedge sys_clk);
    host_e_wr_n <= split_m;
    repeat (4) @(posedge sys_clk);
    host_cs1_n <= 1'b1;
    host_cs2_n <= 1'b1;
    host_rw_rd_n <= 1'b1;
  endtask
  // display model: latency at fall, word at rise
  always @(posedge sys_clk) begin
    stb = split_m ? (rd_mode ? drd : dwr) : (main_n & sub_n);
    if (!role_m && stb_q && !stb && u_far.t_q.size() > 0) begin
      cs_f = !main_n;
      dt = $realtime - u_far.t_q.pop_front();
      lat = rd_mode ? 875.0 : 1125.0;
      chk(dt > lat - 24.0 && dt < lat + 24.0, 1'b1);
    end
    if (!role_m && !stb_q && stb && !rd_mode && exp_q.size() > 0)
      chk({cs_f, dad, dout}, exp_q.pop_front());
    stb_q = stb;
  end
  // cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      pd_cfg(1'b0, m[0]);
      for (int i = 0; i < 4; i++) begin
        w = $random(seed);
        exp_q.push_back(w[17:0]);
        u_far.send(w[16], 1'b0, w[17], w[15:0], 10);
      end
      repeat (16) @(posedge serial_link_clock);
      chk(exp_q.size(), 0);
      @(posedge sys_clk);
      w = $random(seed);
      disp_data_in <= w[15:0];
      rd_mode <= 1'b1;
      u_far.read_word(1'b1, 1'b1);
      chk(u_far.rd_word, disp_data_in);
      chk(u_far.t_q.size(), 0);
      rd_mode <= 1'b0;
      $display("slave test mode %0d done", m);
    end
    for (int m = 0; m < 2; m++) begin
      pd_cfg(1'b1, m[0]);
      w = $random(seed);
      host_wr(w[17], w[16], w[15:0]);
      for (int k = 0; k < 3000 && !lo_oe; k++) @(posedge sys_clk);
      for (int i = 0; i < 10; i++) begin
        @(serial_link_clock);
        gl[i] = lane_lo;
        gh[i] = lane_hi;
      end
      chk({gh, gl}, {w[15:8], w[17], 1'b0, w[7:0], w[16], 1'b1});
      $display("master test mode %0d done", m);
    end
    close_out();
  end
endmodule // serdes_cpu_port_timing_tb
`default_nettype wire
